// File: core/preset_scan_pkg.sv
package preset_scan_pkg;

   localparam int unsigned CHAN_COUNT = 30;
   localparam int unsigned CHAN_W     = 5;
   localparam int unsigned FREQ_W     = 32;

   // scan timing: full pass of all channels in under half a second
   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned PASS_TIME_MS = 500;
   // longest time rounds down; a margin of one step keeps the pass strictly under
   localparam longint unsigned PASS_CYCLES  = (CLK_HZ * PASS_TIME_MS) / 1000;
   localparam longint unsigned STEP_CYCLES  = PASS_CYCLES / (CHAN_COUNT + 1);

   localparam logic [CHAN_W-1:0] CHAN_FIRST = 5'h00;
   localparam logic [CHAN_W-1:0] CHAN_LAST  = 5'h1D;
   localparam logic [CHAN_W-1:0] CHAN_ONE   = 5'h01;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_STEP  = 3'b010,
      ST_DWELL = 3'b100
   } scanState_t;

   // operator keys and fields
   typedef struct packed {
      logic              sweepKey;
      logic              meterViewKey;
      logic              limitEnable;
      logic [CHAN_W-1:0] lowerChannelLimit;
      logic [CHAN_W-1:0] upperChannelLimit;
   } operatorCtl_t;

   // tuning word toward the receiver
   typedef struct packed {
      logic              tuneValid;
      logic [CHAN_W-1:0] channel;
      logic [FREQ_W-1:0] frequency;
      logic              inputSel;
   } tuneCmd_t;

endpackage : preset_scan_pkg

// File: core/preset_step_timer.sv
`timescale 1ns/10ps
module preset_step_timer #(
   parameter longint unsigned STEP_CYCLES = preset_scan_pkg::STEP_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic run,
   output logic      tick
);

   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_TOP  = CNT_W'(STEP_CYCLES - 1);

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             tick;
   } timerState_t;

   timerState_t state_r;
   timerState_t state_nxt;

   always_comb begin
      state_nxt      = state_r;
      state_nxt.tick = 1'b0;
      if (!run) begin
         // restart so every channel gets a full settle time
         state_nxt.count = CNT_ZERO;
      end else if (state_r.count == CNT_TOP) begin
         state_nxt.count = CNT_ZERO;
         state_nxt.tick  = 1'b1;
      end else begin
         state_nxt.count = state_r.count + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign tick = state_r.tick;

endmodule : preset_step_timer

// File: core/preset_channel_scanner.sv
`timescale 1ns/10ps
module preset_channel_scanner #(
   // cycles per channel; the default keeps a full pass under half a second
   parameter longint unsigned STEP_CYCLES = preset_scan_pkg::STEP_CYCLES
) (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst_n,
   // operator keys and fields
   input  wire preset_scan_pkg::operatorCtl_t         opCtl,
   input  wire logic                                  useSharedPort,
   input  wire logic [1:0]                            modTypeSet,
   input  wire logic [1:0]                            bandwidthSet,
   // channel table write port
   input  wire logic                                  tableWrite,
   input  wire logic [preset_scan_pkg::CHAN_W-1:0]    tableAddr,
   input  wire logic [preset_scan_pkg::FREQ_W-1:0]    tableData,
   // receiver side
   input  wire logic                                  squelchOpen,
   output preset_scan_pkg::tuneCmd_t                  tune,
   output logic [1:0]                                 modType,
   output logic [1:0]                                 bandwidth,
   // status
   output logic                                       scanning,
   output logic                                       dwelling
);

   localparam logic [preset_scan_pkg::CHAN_W-1:0] FIRST = preset_scan_pkg::CHAN_FIRST;
   localparam logic [preset_scan_pkg::CHAN_W-1:0] LAST  = preset_scan_pkg::CHAN_LAST;
   localparam logic [preset_scan_pkg::CHAN_W-1:0] ONE   = preset_scan_pkg::CHAN_ONE;

   typedef struct packed {
      preset_scan_pkg::scanState_t            fsm;
      logic [preset_scan_pkg::CHAN_W-1:0]     channel;
      logic [preset_scan_pkg::FREQ_W-1:0]     frequency;
      logic                                   tuneValid;
      logic                                   inputSel;
      logic [1:0]                             modType;
      logic [1:0]                             bandwidth;
      logic                                   sweepPrev;
      logic                                   meterPrev;
      logic                                   skipOnce;
   } scanState_t;

   scanState_t state_r;
   scanState_t state_nxt;

   // the table is written by the operator side, read by the scanner
   logic [preset_scan_pkg::FREQ_W-1:0] chanTable [preset_scan_pkg::CHAN_COUNT];

   logic                                stepTick;
   logic                                sweepPress;
   logic                                meterPress;
   logic [preset_scan_pkg::CHAN_W-1:0]  loLim;
   logic [preset_scan_pkg::CHAN_W-1:0]  hiLim;
   logic [preset_scan_pkg::CHAN_W-1:0]  nextChan;
   logic                                limitsOk;

   always_ff @(posedge clk) begin
      if (tableWrite && (tableAddr <= LAST)) begin
         chanTable[tableAddr] <= tableData;
      end
   end

   // state decode, shared by the timer and the transition requests
   logic inIdle;
   logic inStep;
   logic inDwell;

   assign inIdle  = (state_r.fsm == preset_scan_pkg::ST_IDLE);
   assign inStep  = (state_r.fsm == preset_scan_pkg::ST_STEP);
   assign inDwell = (state_r.fsm == preset_scan_pkg::ST_DWELL);

   // step timer runs only while stepping; pace gives a pass under half a second
   preset_step_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) stepTimer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (inStep),
      .tick  (stepTick)
   );

   assign sweepPress = opCtl.sweepKey & ~state_r.sweepPrev;
   assign meterPress = opCtl.meterViewKey & ~state_r.meterPrev;

   // bad limits fall back to the whole table rather than scanning nothing
   assign limitsOk = opCtl.limitEnable
                   && (opCtl.lowerChannelLimit <= opCtl.upperChannelLimit)
                   && (opCtl.upperChannelLimit <= LAST);
   assign loLim = limitsOk ? opCtl.lowerChannelLimit : FIRST;
   assign hiLim = limitsOk ? opCtl.upperChannelLimit : LAST;

   always_comb begin
      if ((state_r.channel >= hiLim) || (state_r.channel < loLim)) begin
         nextChan = loLim;
      end else begin
         nextChan = state_r.channel + ONE;
      end
   end

   // one decoded request per transition; the halt key outranks every other
   logic startReq;
   logic haltReq;
   logic dwellReq;
   logic stepReq;
   logic skipReq;
   logic resumeReq;

   // a start needs the sweep key alone; both keys at once stay idle
   assign startReq  = inIdle && sweepPress && !meterPress;
   assign haltReq   = !inIdle && meterPress;
   // the channel just resumed from is not dwelt on again this visit
   assign dwellReq  = inStep && !meterPress && squelchOpen && !state_r.skipOnce;
   assign stepReq   = inStep && !meterPress && !dwellReq && stepTick;
   assign skipReq   = inDwell && !meterPress && sweepPress;
   assign resumeReq = inDwell && !meterPress && !sweepPress && !squelchOpen;

   // combinational reads so frequency and channel number change together
   logic [preset_scan_pkg::FREQ_W-1:0] startFreq;
   logic [preset_scan_pkg::FREQ_W-1:0] nextFreq;

   assign startFreq = chanTable[loLim];
   assign nextFreq  = chanTable[nextChan];

   always_comb begin
      state_nxt           = state_r;
      state_nxt.sweepPrev = opCtl.sweepKey;
      state_nxt.meterPrev = opCtl.meterViewKey;
      state_nxt.inputSel  = useSharedPort;
      // modulation and bandwidth only follow the operator, in every state
      state_nxt.modType   = modTypeSet;
      state_nxt.bandwidth = bandwidthSet;
      unique case (state_r.fsm)
         preset_scan_pkg::ST_IDLE: begin
            if (startReq) begin
               state_nxt.fsm       = preset_scan_pkg::ST_STEP;
               state_nxt.channel   = loLim;
               state_nxt.frequency = startFreq;
               state_nxt.tuneValid = 1'b1;
               state_nxt.skipOnce  = 1'b0;
            end
         end
         preset_scan_pkg::ST_STEP: begin
            if (haltReq) begin
               // channel and frequency left alone so the receiver stays put
               state_nxt.fsm = preset_scan_pkg::ST_IDLE;
            end else if (dwellReq) begin
               state_nxt.fsm = preset_scan_pkg::ST_DWELL;
            end else if (stepReq) begin
               // skip is spent on leaving the skipped channel
               state_nxt.skipOnce  = 1'b0;
               state_nxt.channel   = nextChan;
               state_nxt.frequency = nextFreq;
            end
         end
         preset_scan_pkg::ST_DWELL: begin
            if (haltReq) begin
               state_nxt.fsm = preset_scan_pkg::ST_IDLE;
            end else if (skipReq) begin
               state_nxt.fsm       = preset_scan_pkg::ST_STEP;
               state_nxt.channel   = nextChan;
               state_nxt.frequency = nextFreq;
            end else if (resumeReq) begin
               state_nxt.fsm      = preset_scan_pkg::ST_STEP;
               // pretend a skip so the timer moves on rather than re-dwelling
               state_nxt.skipOnce = 1'b1;
            end
         end
         default: begin
            state_nxt.fsm = preset_scan_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= '0;
         state_r.fsm <= preset_scan_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign tune.tuneValid = state_r.tuneValid;
   assign tune.channel   = state_r.channel;
   assign tune.frequency = state_r.frequency;
   assign tune.inputSel  = state_r.inputSel;
   assign modType        = state_r.modType;
   assign bandwidth      = state_r.bandwidth;
   assign scanning       = (state_r.fsm != preset_scan_pkg::ST_IDLE);
   assign dwelling       = (state_r.fsm == preset_scan_pkg::ST_DWELL);

endmodule : preset_channel_scanner

// File: testbench/preset_scan_monitor.sv
`timescale 1ns/10ps
module preset_scan_monitor (
   // watched ports
   input wire logic                          clk,
   input wire logic                          rst_n,
   input wire preset_scan_pkg::operatorCtl_t opCtl,
   input wire logic                          useSharedPort,
   input wire logic [1:0]                    modTypeSet,
   input wire logic                          squelchOpen,
   input wire preset_scan_pkg::tuneCmd_t     tune,
   input wire logic [1:0]                    modType,
   input wire logic                          scanning,
   input wire logic                          dwelling
);
   logic       limOk;
   logic [4:0] startCh;
   logic [4:0] lo;
   logic [4:0] hi;
   assign lo = opCtl.lowerChannelLimit;
   assign hi = opCtl.upperChannelLimit;
   // bad limits fall back to the whole table
   assign limOk = opCtl.limitEnable && lo <= hi && hi <= 5'h1D;
   assign startCh = limOk ? lo : 5'h00;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sweepPress;
      $rose(opCtl.sweepKey) && !opCtl.meterViewKey;
   endsequence
   sequence quietDwell;
      dwelling && !opCtl.sweepKey && !opCtl.meterViewKey;
   endsequence
   a_sweep_start: assert property (!scanning ##0 sweepPress |=> scanning && tune.tuneValid
      && tune.channel == $past(startCh)) else $error("scan start failed");
   a_meter_halt: assert property (scanning && $rose(opCtl.meterViewKey)
      |=> !scanning && $stable(tune.channel)) else $error("halt failed");
   a_dwell_hold: assert property (quietDwell ##0 squelchOpen
      |=> dwelling && $stable(tune.channel)) else $error("dwell lost");
   a_dwell_end: assert property (quietDwell ##0 !squelchOpen
      |=> !dwelling && $stable(tune.channel)) else $error("dwell not released");
   a_skip_next: assert property (dwelling && !(limOk && lo == hi) ##0 sweepPress
      |=> !dwelling && scanning && !$stable(tune.channel)) else $error("skip failed");
   a_wrap_low: assert property (dwelling && limOk && tune.channel == hi ##0 sweepPress
      |=> tune.channel == $past(lo)) else $error("no wrap to lower limit");
   a_limit_range: assert property (scanning && limOk
      |-> tune.channel >= lo && tune.channel <= hi) else $error("channel out of limits");
   a_mod_fixed: assert property ($past(rst_n)
      |-> modType == $past(modTypeSet)) else $error("modulation altered");
   a_port_sel: assert property ($past(rst_n)
      |-> tune.inputSel == $past(useSharedPort)) else $error("input select wrong");
endmodule : preset_scan_monitor
bind preset_channel_scanner preset_scan_monitor preset_scan_monitor_i (.clk, .rst_n, .opCtl,
   .useSharedPort, .modTypeSet, .squelchOpen, .tune, .modType, .scanning, .dwelling);

// File: testbench/rx_squelch_model.sv
`timescale 1ns/10ps
module rx_squelch_model (
   // tuning and scenario control
   input  wire preset_scan_pkg::tuneCmd_t tune,
   input  wire logic                      carrierOn,
   input  wire logic                      carrierPort,
   // squelch detect
   output logic                           squelchOpen
);
   // squelch breaks only if the carrier sits on the selected input
   assign squelchOpen = carrierOn && tune.inputSel == carrierPort;
endmodule : rx_squelch_model

// File: testbench/preset_channel_scanner_tb_top.sv
`timescale 1ns/10ps
module preset_channel_scanner_tb_top;
   logic                          clk, rst_n, useSharedPort, tableWrite, squelchOpen;
   logic                          carrierOn, carrierPort, scanning, dwelling;
   logic [1:0]                    modTypeSet, bandwidthSet, modType, bandwidth;
   logic [4:0]                    tableAddr;
   logic [31:0]                   tableData;
   logic [4:0]                    skipTo [3] = '{5'h05, 5'h06, 5'h04};
   preset_scan_pkg::operatorCtl_t opCtl;
   preset_scan_pkg::tuneCmd_t     tune;
   int                            nFail, checksDone;
   localparam int                 STEP = 8;
   preset_channel_scanner #(.STEP_CYCLES(STEP)) preset_channel_scanner_i (.clk, .rst_n, .opCtl,
      .useSharedPort, .modTypeSet, .bandwidthSet, .tableWrite, .tableAddr, .tableData,
      .squelchOpen, .tune,
      .modType, .bandwidth, .scanning, .dwelling);
   rx_squelch_model rx_squelch_model_i (.tune, .carrierOn, .carrierPort, .squelchOpen);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrapUp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : cyc
   // key held one cycle, then a low cycle before any next press
   task automatic press(input logic meter);
      cyc(1);
      opCtl.meterViewKey = meter;
      opCtl.sweepKey = !meter;
      cyc(1);
      opCtl.meterViewKey = 1'b0;
      opCtl.sweepKey = 1'b0;
      cyc(1);
   endtask : press
   task automatic tuned(input logic [4:0] ch, input logic dw);
      chk(32'(scanning), 32'h1);
      chk(32'(tune.channel), 32'(ch));
      chk(tune.frequency, 32'hA000_0000 + 32'(ch));
      cyc(1);
      chk(32'(dwelling), 32'(dw));
   endtask : tuned
   initial begin
      #200_000;
      nFail++;
      wrapUp();
   end
   initial begin
      opCtl = '0;
      {useSharedPort, tableWrite, carrierOn, modTypeSet, bandwidthSet} = '0;
      carrierPort = 1'b1;
      tableAddr = 5'h00;
      tableData = 32'h0000_0000;
      nFail = 0;
      checksDone = 0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 30; i++) begin
         tableWrite = 1'b1;
         tableAddr = 5'(i);
         tableData = 32'hA000_0000 + 32'(i);
         cyc(1);
      end
      tableWrite = 1'b0;
      useSharedPort = 1'b1;
      modTypeSet = 2'h2;
      bandwidthSet = 2'h1;
      opCtl.limitEnable = 1'b1;
      opCtl.lowerChannelLimit = 5'h04;
      opCtl.upperChannelLimit = 5'h06;
      carrierOn = 1'b1;
      press(1'b0);
      tuned(5'h04, 1'b1);
      for (int i = 0; i < 3; i++) begin
         press(1'b0);
         tuned(skipTo[i], 1'b1);
      end
      cyc(20);
      tuned(5'h04, 1'b1);
      chk(32'(modType), 32'h2);
      chk(32'(bandwidth), 32'h1);
      carrierOn = 1'b0;
      cyc(1);
      tuned(5'h04, 1'b0);
      press(1'b1);
      chk(32'(scanning), 32'h0);
      chk(32'(tune.channel), 32'h4);
      press(1'b1);
      chk(32'(scanning), 32'h0);
      opCtl.lowerChannelLimit = 5'h07;
      opCtl.upperChannelLimit = 5'h03;
      carrierOn = 1'b1;
      press(1'b0);
      tuned(5'h00, 1'b1);
      useSharedPort = 1'b0;
      cyc(3);
      chk(32'(dwelling), 32'h0);
      carrierPort = 1'b0;
      cyc(STEP + 1);
      tuned(5'h01, 1'b1);
      press(1'b1);
      carrierOn = 1'b0;
      opCtl.lowerChannelLimit = 5'h1B;
      opCtl.upperChannelLimit = 5'h1D;
      press(1'b0);
      tuned(5'h1B, 1'b0);
      cyc(STEP - 2);
      chk(32'(tune.channel), 32'h1B);
      cyc(1);
      chk(32'(tune.channel), 32'h1C);
      chk(tune.frequency, 32'hA000_001C);
      cyc(STEP);
      chk(32'(tune.channel), 32'h1D);
      cyc(STEP);
      chk(32'(tune.channel), 32'h1B);
      press(1'b1);
      chk(32'(scanning), 32'h0);
      chk(32'(tune.channel), 32'h1B);
      wrapUp();
   end
endmodule : preset_channel_scanner_tb_top
